// *** capture_params.svh ***
// Purpose: Constants for the bus-cycle capture queue with prefetch filtering
// Assumes: Included by bare name from the capture package and design files
// Notes:   Definitions only
`ifndef CAPTURE_PARAMS_SVH
`define CAPTURE_PARAMS_SVH

`define CAP_ADDR_W        15       // New/saved address bits 1..15
`define CAP_DATA_W        16       // New data bits 0..15
`define CAP_STAT_W        15       // Queue bits 16..30
`define CAP_WORD_W        31       // Queue word bits 0..30
`define CAP_FLAG_BIT      14       // Bit 30 position inside the status field
`define CAP_PTR_W         2        // Pointer bits
`define CAP_QUEUE_DEPTH   4        // Samples per half section
`define CAP_OFFS_W        8        // Saved offset bits used by the second compare
`define CAP_CODE_W        8        // Pattern code width
`define CAP_PATTERNS      128      // Distinguishable cycle patterns
`define CAP_BUF_DEPTH     16       // Output buffer depth
`define CAP_SYNC_W        3        // Input synchroniser stages

`endif

// *** capture_pkg.sv ***
// Purpose: Types for the capture path
// Assumes: capture_params.svh available
// Notes:   Nothing is imported; use capture_pkg::name
`include "capture_params.svh"
package capture_pkg;
  // Pod operating mode
  typedef enum logic [1:0] {
    MODE_TRANSPARENT,
    MODE_FILTERED,
    MODE_JUMP
  } pod_mode_t;
  // Access type from function codes
  typedef enum logic [1:0] {
    ACC_IGNORE = 2'h0,
    ACC_DATA   = 2'h1,
    ACC_INSTR  = 2'h2,
    ACC_IACK   = 2'h3
  } access_type_t;
  // Second compare selection
  typedef enum logic [1:0] {
    CMP_NONE,
    CMP_SHORT,
    CMP_LONG,
    CMP_JUMP
  } compare_select_t;
  // Capture sequencing per cycle
  typedef enum logic [1:0] {
    PH_IDLE,
    PH_ADDR,
    PH_DATA
  } phase_t;
endpackage

// *** capture_top.sv ***
// Purpose: Capture queue, pattern sequencer and qualifier for a disassembly pod
// Assumes: Strobe and bus lines arrive asynchronously on pins
// Notes:   The address/data halves are 31-bit words; a 16-word buffer feeds the mainframe
`timescale 1ns/1ps
`default_nettype none
`include "capture_params.svh"

//////////////////////////////////////////////////////////////////////////////
// Output buffer between the queue and the mainframe port
module capture_fifo #(
  parameter int WIDTH = 33,
  parameter int DEPTH = 16
) (
  input  wire logic             clock,
  input  wire logic             rst_n,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_reg [DEPTH];  // Storage in flip-flops
  logic [AW-1:0]    wr_reg;           // Write index
  logic [AW-1:0]    rd_reg;           // Read index
  logic [AW:0]      count_reg;        // Occupancy
  logic             push;
  logic             pop;

  assign in_ready  = (count_reg != (AW+1)'(DEPTH));
  assign out_valid = (count_reg != '0);
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  assign out_data  = mem_reg[rd_reg];

  // Storage write
  always_ff @(posedge clock) begin
    if (push) begin
      mem_reg[wr_reg] <= in_data;
    end
  end

  // Indices and occupancy
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      wr_reg    <= '0;
      rd_reg    <= '0;
      count_reg <= '0;
    end else begin
      if (push) begin
        wr_reg <= (wr_reg == AW'(DEPTH-1)) ? '0 : wr_reg + 1'b1;
      end
      if (pop) begin
        rd_reg <= (rd_reg == AW'(DEPTH-1)) ? '0 : rd_reg + 1'b1;
      end
      count_reg <= count_reg + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule // capture_fifo

//////////////////////////////////////////////////////////////////////////////
// Function
// - Data half puts new data on bits 0-15
// - Bits 16-30 come from status/address latches
// - Queue address is pointer plus half select
// - Filtered mode: pointer advances after both halves
// - Transparent mode: pointer stays constant
// - Read enable active except during identity read
// - Old entry presented before overwrite at pointer
// - Transparent mode: qualifier always active
// - Data word decoded to 8-bit pattern code
// - Sync on stored pattern; filter only when synced
// - First compare: saved plus two versus new
// - Short branch: saved plus short offset
// - Long branch: saved plus 8 offset bits
// - Jump: 8 destination bits alone compared
// - Registered compares drive cycle reject
// - Access type encoding; transparent reports acknowledge
// - Ignore type stops sequencer, holds pointer
// - Filtered: data/ack always, instructions if qualified
// - Entry tag used by qualifier on exit
// - Filtered: bit 30 flags fetch versus data
// - Jump mode stores first word, uses reject
// - Jump mode: no discontinuity forces qualifier low
// - Two output sample pulses per captured cycle
// - Jump mode: discontinuity qualifies, then advances pointer
module capture_top #(
  parameter int BUF_DEPTH = `CAP_BUF_DEPTH
) (
  input  wire logic                      clock,
  input  wire logic                      nrst,
  input  wire logic [1:0]                pod_mode_select,   // Static pod mode
  input  wire logic                      identity_read,     // Mainframe reads pod identity
  input  wire logic                      input_strobe,      // Target bus strobe (pin)
  input  wire logic [`CAP_ADDR_W-1:0]    new_address,       // Address bits 1..15
  input  wire logic [`CAP_DATA_W-1:0]    new_data,          // Data bits 0..15
  input  wire logic [`CAP_STAT_W-1:0]    new_status,        // Status/address latch bits
  input  wire logic [1:0]                function_code,     // Processor function bits
  input  wire logic [`CAP_CODE_W-1:0]    stored_pattern,    // Expected pattern code
  input  wire logic [1:0]                branch_class,      // Instruction discontinuity kind
  input  wire logic                      out_ready,         // Mainframe accepts a half
  output logic                           out_valid,         // Half word available
  output logic      [`CAP_WORD_W-1:0]    out_word,          // Half word to mainframe
  output logic                           out_half,          // 1 = data half
  output logic                           capture_qualifier, // Qualifies this half
  output logic                           sample_pulse,      // Output sample clock enable
  output logic                           queue_read_enable_n,
  output logic                           cycle_reject,
  output logic                           synced,
  output logic                           stall              // Buffer full, strobe lost risk
);
  localparam int DEPTH2 = 2 * `CAP_QUEUE_DEPTH;
  localparam int BW     = `CAP_WORD_W + 2;

  logic [1:0] rst_sync_reg;            // Reset release chain
  logic       rst_n;
  logic [`CAP_SYNC_W-1:0] strobe_sync_reg;  // Strobe synchroniser
  logic       strobe_level_reg;        // Last level on which stages two and three agreed
  capture_pkg::pod_mode_t       mode;
  capture_pkg::access_type_t    access_type;
  capture_pkg::compare_select_t compare_select;
  capture_pkg::phase_t          phase_reg;
  logic [`CAP_WORD_W-1:0] queue_reg [DEPTH2];  // Two half sections
  logic       tag_reg [`CAP_QUEUE_DEPTH];      // Instruction tag per entry
  logic       reject_mem_reg [`CAP_QUEUE_DEPTH];
  logic [`CAP_PTR_W-1:0] pointer_reg;
  logic       address_half_select;
  logic [`CAP_PTR_W+0:0] queue_addr;
  logic [`CAP_WORD_W-1:0] write_word;
  logic [`CAP_ADDR_W-1:0] saved_address_reg;
  logic [`CAP_OFFS_W-1:0] saved_offset_reg;
  capture_pkg::compare_select_t saved_sel_reg;
  logic       adder_carry_in;
  logic       saved_output_enable_n;
  logic       first_eq_reg;            // Registered first compare
  logic       second_eq_reg;           // Registered second compare
  logic       synced_reg;
  logic [`CAP_CODE_W-1:0] pattern_code;
  logic       pointer_advance_n;
  logic       force_qualifier_low_n;
  logic       buf_ready;
  logic       present_qual;
  logic       present_valid;

  // Asynchronous assert, synchronous release of reset
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) rst_sync_reg <= 2'h0;
    else       rst_sync_reg <= {rst_sync_reg[0], 1'b1};
  end
  assign rst_n = rst_sync_reg[1];

  // Strobe synchroniser; an edge counts once stages two and three agree
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) strobe_sync_reg <= '0;
    else        strobe_sync_reg <= {strobe_sync_reg[1:0], input_strobe};
  end

  // Accepted strobe level; a lone disagreeing sample never makes an edge
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      strobe_level_reg <= 1'b0;
    end else if (strobe_sync_reg[2] == strobe_sync_reg[1]) begin
      strobe_level_reg <= strobe_sync_reg[2];
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Mode and cycle classification
  // Mode is sampled live; software must hold it still while acquiring
  always_comb begin
    case (pod_mode_select)
      2'h1:    mode = capture_pkg::MODE_FILTERED;
      2'h2:    mode = capture_pkg::MODE_JUMP;
      default: mode = capture_pkg::MODE_TRANSPARENT;
    endcase
  end

  // Transparent mode reports every cycle as acknowledge
  assign access_type = (mode == capture_pkg::MODE_TRANSPARENT) ? capture_pkg::ACC_IACK
                     : capture_pkg::access_type_t'(function_code);

  // Pattern decode: fold the data word into an 8-bit code, low 7 bits carry the pattern
  function automatic logic [`CAP_CODE_W-1:0] decode_pattern(input logic [15:0] d);
    logic [6:0] p;
    p = d[15:9] ^ d[6:0] ^ {d[8:7], d[12:8]};
    return {1'b0, p};
  endfunction
  assign pattern_code = decode_pattern(new_data);

  // Adder and comparator shared by both compare halves
  function automatic logic addr_match(input logic [14:0] base, input logic [7:0] offs,
                                      input logic cin, input logic [14:0] target);
    logic [14:0] sum;
    sum = base + {{7{offs[7]}}, offs} + {14'h0, cin};
    return sum == target;
  endfunction

  assign compare_select = capture_pkg::compare_select_t'(branch_class);

  //////////////////////////////////////////////////////////////////////////
  // Half sequencing: two output sample pulses per captured cycle
  logic strobe_edge;
  assign strobe_edge = (strobe_sync_reg[2:1] == 2'b11) && !strobe_level_reg;
  logic ignore_cycle;
  assign ignore_cycle = (access_type == capture_pkg::ACC_IGNORE);

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      phase_reg <= capture_pkg::PH_IDLE;
    end else begin
      case (phase_reg)
        capture_pkg::PH_IDLE: if (strobe_edge && buf_ready) phase_reg <= capture_pkg::PH_ADDR;
        capture_pkg::PH_ADDR: if (buf_ready) phase_reg <= capture_pkg::PH_DATA;
        capture_pkg::PH_DATA: if (buf_ready) phase_reg <= capture_pkg::PH_IDLE;
        default:              phase_reg <= capture_pkg::PH_IDLE;
      endcase
    end
  end
  logic write_en;
  assign address_half_select = (phase_reg == capture_pkg::PH_ADDR);
  assign write_en     = (phase_reg != capture_pkg::PH_IDLE) && buf_ready;
  assign sample_pulse = write_en;
  assign stall        = !buf_ready;

  //////////////////////////////////////////////////////////////////////////
  // Queue word assembly and addressing
  // Data half drives new data low; status flag 30 becomes the fetch flag when filtering
  always_comb begin
    write_word = '0;
    if (address_half_select) begin
      write_word = {new_status, 1'b0, new_address};
    end else begin
      write_word[`CAP_DATA_W-1:0] = new_data;
      write_word[`CAP_WORD_W-1:`CAP_DATA_W] = new_status;
      if (mode != capture_pkg::MODE_TRANSPARENT) begin
        write_word[`CAP_DATA_W+`CAP_FLAG_BIT] = !saved_output_enable_n;
      end
    end
  end
  assign queue_addr = {!address_half_select, pointer_reg};

  // Entry tag: instruction cycles are held back until qualified
  assign saved_output_enable_n = (access_type != capture_pkg::ACC_INSTR);

  // Entry at pointer is read before the write replaces it
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      present_valid <= 1'b0;
      present_qual  <= 1'b0;
    end else if (write_en) begin
      // Valid only from the first finished pair, so halves leave in pairs
      present_valid <= present_valid || !address_half_select;
      present_qual  <= (mode == capture_pkg::MODE_TRANSPARENT) ? 1'b1
                     : (tag_reg[pointer_reg] ? !reject_mem_reg[pointer_reg] : 1'b1);
    end
  end

  always_ff @(posedge clock) begin
    if (write_en) begin
      queue_reg[queue_addr] <= write_word;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Sequencer: sync, compares, reject
  assign adder_carry_in = address_half_select;
  logic first_now;
  logic second_now;
  assign first_now = addr_match(saved_address_reg, 8'h0, adder_carry_in, new_address);
  always_comb begin
    case (saved_sel_reg)
      capture_pkg::CMP_SHORT: second_now = addr_match(saved_address_reg, saved_offset_reg,
                                                      1'b0, new_address);
      capture_pkg::CMP_LONG:  second_now = addr_match(saved_address_reg, saved_offset_reg,
                                                      1'b0, new_address);
      capture_pkg::CMP_JUMP:  second_now = ({7'h0, saved_offset_reg} == new_address);
      default:                second_now = first_now;
    endcase
  end

  // Sequencer clock is withheld on ignore cycles
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      synced_reg        <= 1'b0;
      first_eq_reg      <= 1'b1;
      second_eq_reg     <= 1'b1;
      saved_address_reg <= '0;
      saved_offset_reg  <= '0;
      saved_sel_reg     <= capture_pkg::CMP_NONE;
    end else if (write_en && !ignore_cycle) begin
      if (address_half_select) begin
        first_eq_reg <= first_now;
      end else begin
        second_eq_reg     <= second_now;
        synced_reg        <= (pattern_code == stored_pattern);
        saved_address_reg <= new_address;
        saved_offset_reg  <= new_data[`CAP_OFFS_W-1:0];
        saved_sel_reg     <= compare_select;
      end
    end
  end

  // Reject only when synced and the first compare, plus the second unless none is selected, shows a discontinuity
  assign cycle_reject = synced_reg && !first_eq_reg
                        && (saved_sel_reg == capture_pkg::CMP_NONE || !second_eq_reg);
  assign synced = synced_reg;

  // Tag and reject stored alongside the entry
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < `CAP_QUEUE_DEPTH; i++) begin
        tag_reg[i]        <= 1'b0;
        reject_mem_reg[i] <= 1'b0;
      end
    end else if (write_en && !address_half_select) begin
      tag_reg[pointer_reg]        <= !saved_output_enable_n;
      reject_mem_reg[pointer_reg] <= cycle_reject && (mode == capture_pkg::MODE_FILTERED);
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Pointer control
  // Jump mode: only discontinuities release the qualifier and the pointer
  assign force_qualifier_low_n = (mode != capture_pkg::MODE_JUMP)
                                 || cycle_reject;
  assign pointer_advance_n = (mode == capture_pkg::MODE_TRANSPARENT)
                           || ignore_cycle
                           || !force_qualifier_low_n;
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      pointer_reg <= '0;
    end else if (write_en && !address_half_select && !pointer_advance_n) begin
      pointer_reg <= pointer_reg + 1'b1;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Output buffer and read port
  assign queue_read_enable_n = identity_read;
  logic [BW-1:0] buf_in;
  logic [BW-1:0] buf_out;
  logic          qual_in;
  assign qual_in = (mode == capture_pkg::MODE_JUMP) ? force_qualifier_low_n && present_qual
                                                     : present_qual;
  assign buf_in = {qual_in, !address_half_select,
                   queue_read_enable_n ? `CAP_WORD_W'(0) : queue_reg[queue_addr]};

  capture_fifo #(.WIDTH(BW), .DEPTH(BUF_DEPTH)) u_buf (
    .clock     (clock),
    .rst_n     (rst_n),
    .in_valid  (write_en && present_valid),
    .in_ready  (buf_ready),
    .in_data   (buf_in),
    .out_valid (out_valid),
    .out_ready (out_ready),
    .out_data  (buf_out)
  );
  assign capture_qualifier = out_valid && buf_out[BW-1];
  assign out_half          = buf_out[BW-2];
  assign out_word          = buf_out[`CAP_WORD_W-1:0];

  //////////////////////////////////////////////////////////////////////////
  // Checks
  AST_TRANSPARENT_HOLD: assert property (@(posedge clock) disable iff (!rst_n)
    (mode == capture_pkg::MODE_TRANSPARENT) |=> $stable(pointer_reg))
    else $error("pointer moved in transparent mode");
  AST_READ_ENABLE: assert property (@(posedge clock) disable iff (!rst_n)
    queue_read_enable_n == identity_read) else $error("read enable wrong");
  AST_IGNORE_HOLD: assert property (@(posedge clock) disable iff (!rst_n)
    (write_en && ignore_cycle) |=> $stable(pointer_reg)) else $error("ignore advanced pointer");
  AST_TWO_HALVES: assert property (@(posedge clock) disable iff (!rst_n)
    (phase_reg == capture_pkg::PH_ADDR && buf_ready) |=> phase_reg == capture_pkg::PH_DATA)
    else $error("data half missing");
  AST_TRANSP_QUAL: assert property (@(posedge clock) disable iff (!rst_n)
    (mode == capture_pkg::MODE_TRANSPARENT && write_en) |=> present_qual)
    else $error("transparent qualifier low");
  AST_DATA_HALF: assert property (@(posedge clock) disable iff (!rst_n)
    (phase_reg == capture_pkg::PH_DATA) |-> write_word[15:0] == new_data)
    else $error("data half bits wrong");
  AST_ADVANCE_ONCE: assert property (@(posedge clock) disable iff (!rst_n)
    (write_en && address_half_select) |=> $stable(pointer_reg)) else $error("early advance");
  AST_ACK_TYPE: assert property (@(posedge clock) disable iff (!rst_n)
    (mode == capture_pkg::MODE_TRANSPARENT) |-> access_type == capture_pkg::ACC_IACK)
    else $error("transparent type not acknowledge");
  AST_JUMP_HOLD: assert property (@(posedge clock) disable iff (!rst_n)
    (mode == capture_pkg::MODE_JUMP && !cycle_reject && write_en) |=> $stable(pointer_reg))
    else $error("pointer moved without discontinuity");
endmodule // capture_top
`default_nettype wire

// *** mainframe_sink.sv ***
// Purpose: Behavioural mainframe acquisition input that pops the capture buffer
// Assumes: capture_params.svh gives the half-word width
// Notes:   Keeps the last popped data half and counts qualified pops
`timescale 1ns/1ps
`default_nettype none
`include "capture_params.svh"

//////////////////////////////////////////////////////////////////////////////
module mainframe_sink (
  input  wire logic                   clock,
  input  wire logic                   rst_n,
  input  wire logic                   hold,              // Stall request from the bench
  input  wire logic                   out_valid,
  input  wire logic [`CAP_WORD_W-1:0] out_word,
  input  wire logic                   out_half,
  input  wire logic                   capture_qualifier,
  output logic                        out_ready,         // Changes only after an edge
  output logic      [`CAP_WORD_W-1:0] last_data,         // Last data half taken
  output logic                        last_qual,         // Its qualifier
  output int                          qual_count,        // Qualified halves taken
  output int                          pop_count          // All halves taken
);
  // Registered ready, so a stall never lands in mid-handshake
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      out_ready  <= 1'b0;
      last_data  <= '0;
      last_qual  <= 1'b0;
      qual_count <= 0;
      pop_count  <= 0;
    end else begin
      out_ready <= !hold;
      // A half is taken at the edge where valid and ready are both high
      if (out_valid && out_ready) begin
        pop_count  <= pop_count + 1;
        qual_count <= qual_count + (capture_qualifier ? 1 : 0);
        if (out_half) begin
          last_data <= out_word;
          last_qual <= capture_qualifier;
        end
      end
    end
  end
endmodule // mainframe_sink
`default_nettype wire

// *** capture_top_tb_top.sv ***
// Purpose: Self-checking bench for the capture queue in all three pod modes
// Assumes: Inputs change at the falling edge; the sink pops on rising edges
// Notes:   Each capture holds its inputs well past the six-cycle window
`timescale 1ns/1ps
`default_nettype none
`include "capture_params.svh"

//////////////////////////////////////////////////////////////////////////////
module capture_top_tb_top;
  typedef struct { logic [15:0] d; logic [14:0] s; logic [14:0] a; logic [1:0] fc;
                   logic [30:0] exp; } row_t;
  logic        clock = 1'b0;
  logic        nrst = 1'b0;
  logic [1:0]  pod_mode_select = 2'h0;
  logic        identity_read = 1'b0;
  logic        input_strobe = 1'b0;
  logic [14:0] new_address = 15'h0000;
  logic [15:0] new_data = 16'h0000;
  logic [14:0] new_status = 15'h0000;
  logic [1:0]  function_code = 2'h1;
  logic [7:0]  stored_pattern = 8'h00;
  logic [1:0]  branch_class = 2'h0;
  logic        hold = 1'b0;                    // Sink stall
  logic        out_ready, out_valid, out_half, capture_qualifier, sample_pulse;
  logic        queue_read_enable_n, cycle_reject, synced, stall, last_qual;
  logic [30:0] out_word, last_data;
  int          qual_count, pop_count, q0, p0;
  int          pulses = 0;                     // Sample pulses seen so far
  int          num_errors = 0;
  int          cmp_count = 0;
  // Ordinary transparent cases: each capture pushes the previous one
  row_t rows [0:4] = '{
    '{16'ha5a5, 15'h1234, 15'h0010, 2'h3, 31'h0},
    '{16'h5a5a, 15'h7fff, 15'h0011, 2'h1, {15'h1234, 16'ha5a5}},
    '{16'hffff, 15'h0000, 15'h0012, 2'h2, {15'h7fff, 16'h5a5a}},
    '{16'h0001, 15'h4000, 15'h7fff, 2'h0, {15'h0000, 16'hffff}},
    '{16'h8000, 15'h2aaa, 15'h0000, 2'h3, {15'h4000, 16'h0001}}};

  always #2 clock = ~clock;
  // Count output sample pulses on the sampling edge
  always @(posedge clock) if (sample_pulse === 1'b1) pulses++;

  capture_top i_capture_top (.clock(clock), .nrst(nrst), .pod_mode_select(pod_mode_select),
    .identity_read(identity_read), .input_strobe(input_strobe), .new_address(new_address),
    .new_data(new_data), .new_status(new_status), .function_code(function_code),
    .stored_pattern(stored_pattern), .branch_class(branch_class), .out_ready(out_ready),
    .out_valid(out_valid), .out_word(out_word), .out_half(out_half),
    .capture_qualifier(capture_qualifier), .sample_pulse(sample_pulse),
    .queue_read_enable_n(queue_read_enable_n), .cycle_reject(cycle_reject),
    .synced(synced), .stall(stall));
  mainframe_sink i_mainframe_sink (.clock(clock), .rst_n(nrst), .hold(hold),
    .out_valid(out_valid), .out_word(out_word), .out_half(out_half),
    .capture_qualifier(capture_qualifier), .out_ready(out_ready), .last_data(last_data),
    .last_qual(last_qual), .qual_count(qual_count), .pop_count(pop_count));

  // Compare and count; four-state compare so unknowns never match
  task automatic chk(input string what, input logic [30:0] seen, input logic [30:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // Mode is static, so it only changes while reset is held
  task automatic do_reset(input logic [1:0] mode);
    @(negedge clock);
    nrst = 1'b0;
    pod_mode_select = mode;
    repeat (5) @(negedge clock);
    nrst = 1'b1;
    repeat (6) @(negedge clock);
  endtask

  // One bus cycle: inputs held from strobe until long after the edge is seen
  task automatic capture(input logic [15:0] d, input logic [14:0] a, input logic [1:0] fc);
    int n;
    @(negedge clock);
    new_data = d;
    new_address = a;
    function_code = fc;
    n = pulses;
    input_strobe = 1'b1;
    repeat (7) @(negedge clock);
    input_strobe = 1'b0;
    repeat (5) @(negedge clock);
    if (!hold) chk("pulses", 31'(pulses - n), 31'd2);
  endtask

  // Hang guard
  initial begin
    #200000;
    num_errors++;
    give_verdict();
  end

  initial begin
    do_reset(2'h0);
    chk("valid_after_reset", 31'(out_valid), 31'd0);
    chk("reject_after_reset", 31'(cycle_reject), 31'd0);
    identity_read = 1'b1;
    #1 chk("read_en_n_id", 31'(queue_read_enable_n), 31'd1);
    identity_read = 1'b0;
    #1 chk("read_en_n", 31'(queue_read_enable_n), 31'd0);
    // Transparent table
    foreach (rows[i]) begin
      new_status = rows[i].s;
      capture(rows[i].d, rows[i].a, rows[i].fc);
      if (i > 0) chk("data_half", last_data, rows[i].exp);
      if (i > 0) chk("transp_qual", 31'(last_qual), 31'd1);
      $display("row %0d done", i);
    end
    // Filtered: four-deep queue, data always qualified, ignore holds pointer
    do_reset(2'h1);
    new_status = 15'h7fff;
    for (int k = 0; k < 11; k++) begin
      if (k == 8) chk("fetch_flag", 31'(last_data[30]), 31'd0);
      capture(16'h1000 + 16'(k), 15'h0200 + 15'(k), (k == 8) ? 2'h0 : 2'h1);
      if (k >= 4 && k < 8) chk("filt_data", 31'(last_data[15:0]), 31'h1000 + 31'(k - 4));
      if (k >= 4 && k < 8) chk("filt_qual", 31'(last_qual), 31'd1);
    end
    chk("after_ignore", 31'(last_data[15:0]), 31'h1005);
    $display("filtered test done");
    // Jump: straight-line fetches never qualify
    do_reset(2'h2);
    q0 = qual_count;
    for (int k = 0; k < 6; k++) capture(16'h4e71, 15'h0100 + 15'(k), 2'h2);
    chk("jump_qual", 31'(qual_count - q0), 31'd0);
    // Sync on a matching pattern, then leave the straight line: one half qualifies
    capture(16'h0000, 15'h0106, 2'h2);
    chk("synced", 31'(synced), 31'd1);
    capture(16'h0000, 15'h0140, 2'h2);
    chk("jump_reject", 31'(cycle_reject), 31'd1);
    chk("jump_disc_qual", 31'(qual_count - q0), 31'd1);
    $display("jump test done");
    // Buffer fills while the sink stalls, then drains to empty
    hold = 1'b1;
    do_reset(2'h0);
    p0 = pop_count;
    for (int k = 0; k < 10; k++) capture(16'h2000 + 16'(k), 15'h0300, 2'h1);
    chk("stall_full", 31'(stall), 31'd1);
    hold = 1'b0;
    for (int t = 0; t < 200 && out_valid !== 1'b0; t++) @(negedge clock);
    @(negedge clock);
    chk("drained", 31'(out_valid), 31'd0);
    chk("stall_clear", 31'(stall), 31'd0);
    chk("pops", 31'(pop_count - p0), 31'd16);
    chk("last_kept", 31'(last_data[15:0]), 31'h2007);
    $display("buffer test done");
    give_verdict();
  end
endmodule // capture_top_tb_top
`default_nettype wire
